// file: src/cvr_top.sv
// Comparator output synchroniser, timer gate select and voltage reference control.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module cvr_top
   import cvr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Timer clock sources and timer state.
   input wire logic timer_clk_raw,
   input wire logic timer_clk_prescaled,
   input wire logic timer_prescale_on,
   input wire logic timer_on,
   input wire logic timer_gate_enable,
   // Comparator and gate pin.
   input wire logic second_comparator_out,
   input wire logic external_gate_pin,
   // Timer gate, count and comparator sync outputs.
   output logic timer_gate,
   output logic timer_count_pulse,
   output logic comparator_sync_out,
   // Voltage reference outputs.
   output logic reference_enable,
   output logic [REF_OUT_W-1:0] comparator_reference_output
);
   logic [1:0] rst_q;
   logic rst_n;
   logic dp_valid;
   logic dp_write;
   logic [ADDR_DEC_W-1:0] dp_addr;
   logic next_dp_valid;
   logic next_dp_write;
   logic [ADDR_DEC_W-1:0] next_dp_addr;
   logic [7:0] comparator_gate_sync_config;
   logic [7:0] voltage_reference_control;
   logic [7:0] next_cfg;
   logic [7:0] next_vref;
   logic cmp_latched;
   logic next_cmp_latched;
   logic timer_clk_sel;
   logic clk_rise;
   logic clk_fall;
   logic cmp_path;
   logic wr_cfg;
   logic wr_vref;

   // Reset is released through two flops so that its removal is clean against clk_sys.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // Address phase is captured when the bus is ready and the slave is selected.
   always_comb begin
      next_dp_valid = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
      next_dp_write = hwrite;
      next_dp_addr = haddr[ADDR_DEC_W-1:0];
      if (!hready) begin
         next_dp_valid = dp_valid;
         next_dp_write = dp_write;
         next_dp_addr = dp_addr;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else begin
         dp_valid <= next_dp_valid;
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
      end
   end

   assign wr_cfg = dp_valid && dp_write && dp_addr == ADDR_GATE_SYNC_CFG[ADDR_DEC_W-1:0];
   assign wr_vref = dp_valid && dp_write && dp_addr == ADDR_VREF_CTRL[ADDR_DEC_W-1:0];

   // Register writes land at the end of the data phase; unmapped writes are dropped.
   // Masking on write keeps unimplemented bits at zero so reads need no extra gating.
   always_comb begin
      next_cfg = comparator_gate_sync_config;
      next_vref = voltage_reference_control;
      if (wr_cfg) begin
         next_cfg = hwdata[7:0] & CFG_MASK;
      end
      if (wr_vref) begin
         next_vref = hwdata[7:0] & VREF_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         comparator_gate_sync_config <= CFG_RESET;
         voltage_reference_control <= VREF_RESET;
      end else begin
         comparator_gate_sync_config <= next_cfg;
         voltage_reference_control <= next_vref;
      end
   end

   // Read data is a mux of flops, so a read right after a write sees the new value.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (dp_valid && !dp_write) begin
         if (dp_addr == ADDR_GATE_SYNC_CFG[ADDR_DEC_W-1:0]) begin
            hrdata = {24'h00_0000, comparator_gate_sync_config};
         end else if (dp_addr == ADDR_VREF_CTRL[ADDR_DEC_W-1:0]) begin
            hrdata = {24'h00_0000, voltage_reference_control};
         end
      end
   end

   // Every access completes without wait states and with an OKAY answer.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // The latch follows the prescaled clock when the prescaler is in use.
   assign timer_clk_sel = timer_prescale_on ? timer_clk_prescaled : timer_clk_raw;

   cvr_edge_det #(
      .W(1)
   ) u_clk_edge (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .level(timer_clk_sel),
      .rise(clk_rise),
      .fall(clk_fall)
   );

   // Comparator is caught on the falling edge so it is stable when the timer counts on rising.
   always_comb begin
      next_cmp_latched = cmp_latched;
      if (clk_fall) begin
         next_cmp_latched = second_comparator_out;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmp_latched <= 1'b0;
      end else begin
         cmp_latched <= next_cmp_latched;
      end
   end

   // Sync and gate selects; the unsynchronised path is a known race hazard left to software.
   assign cmp_path = comparator_gate_sync_config[CFG_SYNC_BIT] ? cmp_latched
                                                               : second_comparator_out;
   assign timer_gate = comparator_gate_sync_config[CFG_GSS_BIT] ? external_gate_pin
                                                               : cmp_path;
   assign comparator_sync_out = cmp_path;

   // Counting happens on rising edges only, gated when the timer runs with gating on.
   assign timer_count_pulse = clk_rise && timer_on
                              && (!timer_gate_enable || timer_gate);

   // Reference controls come only from their own register.
   assign reference_enable = voltage_reference_control[VREF_EN_BIT];

   cvr_ref_level #(
      .LEVEL_W(VREF_LEVEL_W)
   ) u_ref (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(voltage_reference_control[VREF_EN_BIT]),
      .range_low(voltage_reference_control[VREF_RANGE_BIT]),
      .level(voltage_reference_control[VREF_LEVEL_LSB +: VREF_LEVEL_W]),
      .level_96(comparator_reference_output)
   );

   // Bus write sequences used by the checks below.
   sequence vref_write_s;
      wr_vref;
   endsequence

   sequence cfg_write_s;
      wr_cfg;
   endsequence

   sync_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clk_fall |=> cmp_latched == $past(second_comparator_out))
      else $error("Comparator not latched on timer clock fall.");

   latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !clk_fall |=> $stable(cmp_latched))
      else $error("Comparator latch moved away from a falling edge.");

   prescale_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clk_fall |-> $past(timer_prescale_on ? timer_clk_prescaled : timer_clk_raw)
                   && !timer_clk_sel)
      else $error("Latch edge not taken from the selected timer clock.");

   count_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timer_count_pulse |-> timer_clk_sel && !$past(timer_clk_sel) && !clk_fall)
      else $error("Timer counted off a rising edge.");

   sync_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !comparator_gate_sync_config[CFG_GSS_BIT] |-> timer_gate ==
         (comparator_gate_sync_config[CFG_SYNC_BIT] ? cmp_latched : second_comparator_out))
      else $error("Sync select routed the wrong comparator path.");

   gate_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_gate_sync_config[CFG_GSS_BIT] |-> timer_gate == external_gate_pin)
      else $error("Gate pin not selected as timer gate.");

   cfg_unimpl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> comparator_gate_sync_config[7:2] == 6'h00
                      && hrdata[31:8] == 24'h00_0000)
      else $error("Config unimplemented bits are not zero.");

   ref_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      vref_write_s |=> voltage_reference_control == ($past(hwdata[7:0]) & 8'hAF)
                       ##1 reference_enable == voltage_reference_control[7])
      else $error("Reference control did not take the written value.");

   ref_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reference_enable [*2] |-> comparator_reference_output == 7'h00)
      else $error("Disabled reference is not at ground.");

   ref_indep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s and !wr_vref |=> $stable(voltage_reference_control))
      else $error("Comparator config write disturbed the reference.");

   gate_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timer_count_pulse |-> timer_on && (!timer_gate_enable || timer_gate))
      else $error("Timer counted while off or gated shut.");

   // A reference write, then one cycle in which the new fields sit in the register.
   sequence ref_low_on_s;
      vref_write_s ##1 (voltage_reference_control[VREF_EN_BIT]
         && voltage_reference_control[VREF_RANGE_BIT]);
   endsequence

   sequence ref_high_on_s;
      vref_write_s ##1 (voltage_reference_control[VREF_EN_BIT]
         && !voltage_reference_control[VREF_RANGE_BIT]);
   endsequence

   sequence ref_off_s;
      vref_write_s ##1 !voltage_reference_control[VREF_EN_BIT];
   endsequence

   // The reference output is registered, so it trails the register by one cycle.
   ref_range_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_low_on_s |=> comparator_reference_output
         == 7'(7'h04 * $past(voltage_reference_control[VREF_LEVEL_LSB +: VREF_LEVEL_W])))
      else $error("Low range not used while the range bit is set.");

   ref_range_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_high_on_s |=> comparator_reference_output
         == 7'(7'h18 + 7'h03 * $past(voltage_reference_control[VREF_LEVEL_LSB +: VREF_LEVEL_W])))
      else $error("High range level step is wrong.");

   ref_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_off_s |=> comparator_reference_output == 7'h00)
      else $error("Reference not grounded after its enable was cleared.");

   ref_en_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      vref_write_s |=> reference_enable == $past(hwdata[VREF_EN_BIT]))
      else $error("Reference enable did not follow its written bit.");

   vref_unimpl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !voltage_reference_control[6] && !voltage_reference_control[4])
      else $error("Reference unimplemented bits are not zero.");

   cfg_unused_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_gate_sync_config[7:2] == 6'h00)
      else $error("Config unimplemented bits hold a one.");

   cfg_take_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> comparator_gate_sync_config[1:0] == $past(hwdata[1:0]))
      else $error("Config register did not take the written selects.");

   // Read data checks cover the bus side, where a mux slip would hide unimplemented bits.
   rd_cfg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dp_valid && !dp_write && dp_addr == ADDR_GATE_SYNC_CFG[ADDR_DEC_W-1:0]
         |-> hrdata == {30'h0, comparator_gate_sync_config[1:0]})
      else $error("Config read returned wrong bits.");

   rd_vref_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dp_valid && !dp_write && dp_addr == ADDR_VREF_CTRL[ADDR_DEC_W-1:0]
         |-> hrdata[31:8] == 24'h00_0000 && !hrdata[6] && !hrdata[4])
      else $error("Reference read returned unimplemented bits set.");

   reset_val_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> comparator_gate_sync_config == CFG_RESET)
      else $error("Config register left reset with a wrong value.");

   reset_ref_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> voltage_reference_control == VREF_RESET
         && comparator_reference_output == 7'h00)
      else $error("Reference left reset with a wrong value.");

   async_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !comparator_gate_sync_config[CFG_SYNC_BIT] |-> comparator_sync_out == second_comparator_out)
      else $error("Asynchronous comparator path not routed.");

   // With sync on, the output may move only one cycle after a timer clock fall.
   sync_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      comparator_gate_sync_config[CFG_SYNC_BIT] && !clk_fall
         ##1 comparator_gate_sync_config[CFG_SYNC_BIT] |-> $stable(comparator_sync_out))
      else $error("Synchronised comparator output moved without a clock fall.");

   pulse_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timer_count_pulse |=> !timer_count_pulse)
      else $error("Timer count pulse lasted more than one cycle.");
endmodule // cvr_top

// file: src/cvr_pkg.sv
// Package with register map, field layout and reset values for the comparator sync block.
package cvr_pkg;
   // Register byte addresses.
   localparam logic [31:0] ADDR_GATE_SYNC_CFG = 32'h0000_0000;
   localparam logic [31:0] ADDR_VREF_CTRL = 32'h0000_0004;
   localparam int ADDR_DEC_W = 8;
   // Gate and sync configuration fields.
   localparam int CFG_SYNC_BIT = 0;
   localparam int CFG_GSS_BIT = 1;
   localparam logic [7:0] CFG_MASK = 8'h03;
   localparam logic [7:0] CFG_RESET = 8'h02;
   // Voltage reference control fields.
   localparam int VREF_EN_BIT = 7;
   localparam int VREF_RANGE_BIT = 5;
   localparam int VREF_LEVEL_LSB = 0;
   localparam int VREF_LEVEL_W = 4;
   localparam logic [7:0] VREF_MASK = 8'hAF;
   localparam logic [7:0] VREF_RESET = 8'h00;
   // Reference level is expressed in 96ths of the supply, the common multiple of 24, 32 and 4.
   localparam int REF_OUT_W = 7;
   localparam logic [6:0] REF_LOW_SCALE = 7'h04;
   localparam logic [6:0] REF_HIGH_SCALE = 7'h03;
   localparam logic [6:0] REF_HIGH_BASE = 7'h18;
   // AHB transfer type bit that marks an active transfer.
   localparam int HTRANS_ACTIVE_BIT = 1;
endpackage

// file: src/cvr_edge_det.sv
// Edge detector that flags rising and falling edges of a sampled level.
`timescale 1ns/100ps
module cvr_edge_det #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Level in, edge pulses out.
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev;
   logic [W-1:0] next_prev;
   logic primed;
   logic next_primed;

   if (W < 1) begin : g_chk
      $error("cvr_edge_det needs W of at least 1.");
   end

   // Previous sample follows the input every cycle; primed marks that it holds a real sample.
   always_comb begin
      next_prev = level;
      next_primed = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '0;
         primed <= 1'b0;
      end else begin
         prev <= next_prev;
         primed <= next_primed;
      end
   end

   // Pulses last exactly one cycle after the level changes.
   // The first sample after reset only loads prev, so a level already high is no false edge.
   assign rise = level & ~prev & {W{primed}};
   assign fall = ~level & prev & {W{primed}};
endmodule // cvr_edge_det

// file: src/cvr_ref_level.sv
// Reference level calculator that turns the control fields into a 96ths-of-supply code.
`timescale 1ns/100ps
module cvr_ref_level
   import cvr_pkg::*;
#(
   parameter int LEVEL_W = VREF_LEVEL_W
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control fields.
   input wire logic enable,
   input wire logic range_low,
   input wire logic [LEVEL_W-1:0] level,
   // Reference code in 96ths of the supply.
   output logic [REF_OUT_W-1:0] level_96
);
   logic [REF_OUT_W-1:0] next_level_96;
   logic [REF_OUT_W-1:0] lvl_w;

   if (LEVEL_W != 4) begin : g_chk
      $error("cvr_ref_level supports only a four-bit level field.");
   end

   // Scale the field; the low range steps by 1/24, the high one by 1/32 above 1/4.
   always_comb begin
      lvl_w = {{(REF_OUT_W - LEVEL_W){1'b0}}, level};
      if (!enable) begin
         next_level_96 = '0;
      end else if (range_low) begin
         next_level_96 = 7'(lvl_w * REF_LOW_SCALE);
      end else begin
         next_level_96 = 7'(REF_HIGH_BASE + lvl_w * REF_HIGH_SCALE);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_96 <= '0;
      end else begin
         level_96 <= next_level_96;
      end
   end

   ref_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      enable && range_low |=> level_96 == 7'(4 * $past(level)))
      else $error("Low range reference code is wrong.");

   ref_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      enable && !range_low |=> level_96 == 7'(24 + 3 * $past(level)))
      else $error("High range reference code is wrong.");
endmodule // cvr_ref_level

// file: verification/cvr_partner.sv
// Behavioural model of the timer clock source, its prescaler, the comparator and the gate pin.
`timescale 1ns/100ps
module cvr_partner (
   // Clock and levels from the bench.
   input wire logic clk_sys,
   input wire logic cmp_level,
   input wire logic pin_level,
   // Signals seen by the block.
   output logic timer_clk_raw,
   output logic timer_clk_prescaled,
   output logic second_comparator_out,
   output logic external_gate_pin
);
   localparam int HALF = 4;
   int cnt = 0;
   initial begin
      timer_clk_raw = 1'b0;
      timer_clk_prescaled = 1'b0;
   end
   // Each phase lasts several system cycles, so the block can see every edge.
   always @(posedge clk_sys) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         timer_clk_raw <= ~timer_clk_raw;
         // The prescaler halves the source on its rising edges.
         if (!timer_clk_raw) begin
            timer_clk_prescaled <= ~timer_clk_prescaled;
         end
      end
   end
   // The comparator and the pin are plain levels.
   assign second_comparator_out = cmp_level;
   assign external_gate_pin = pin_level;
endmodule // cvr_partner

// file: verification/test_comparator_sync_and_vref_control.sv
// Self-checking bench for the comparator sync, gate select and reference control block.
`timescale 1ns/100ps
module test_comparator_sync_and_vref_control
   import cvr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, gate, cpulse, csync, ref_en, raw, psc, cmp_o, pin_o, tsel;
   logic [31:0] hrdata;
   logic [6:0] ref_out;
   logic pre = 1'b0, t_on = 1'b0, g_en = 1'b0, cmp = 1'b0, pin = 1'b0;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   // Address, write data and expected read-back of each register case.
   logic [7:0] rows [9][3] = '{'{8'h00, 8'hFF, 8'h03}, '{8'h00, 8'h00, 8'h00},
      '{8'h00, 8'h01, 8'h01}, '{8'h00, 8'h02, 8'h02}, '{8'h04, 8'hFF, 8'hAF},
      '{8'h04, 8'h5A, 8'h0A}, '{8'h04, 8'h20, 8'h20}, '{8'h08, 8'hFF, 8'h00},
      '{8'h04, 8'h00, 8'h00}};

   // The clock flips every half period.
   always #4 clk_sys = ~clk_sys;
   assign tsel = pre ? psc : raw;

   cvr_top dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_clk_raw(raw),
      .timer_clk_prescaled(psc), .timer_prescale_on(pre), .timer_on(t_on),
      .timer_gate_enable(g_en), .second_comparator_out(cmp_o), .external_gate_pin(pin_o),
      .timer_gate(gate), .timer_count_pulse(cpulse), .comparator_sync_out(csync),
      .reference_enable(ref_en), .comparator_reference_output(ref_out));

   cvr_partner far (.clk_sys(clk_sys), .cmp_level(cmp), .pin_level(pin),
      .timer_clk_raw(raw), .timer_clk_prescaled(psc), .second_comparator_out(cmp_o),
      .external_gate_pin(pin_o));

   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single transfer; entered just after a rising edge, holds each phase until ready.
   task xfer(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, d, x);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] r);
      xfer(a, 1'b0, 8'h00, r);
   endtask

   // Bus requests wait for the third edge after release, as the synchroniser needs.
   task do_reset;
      rstn <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask

   task chk_reset;
      logic [31:0] r;
      rd(8'h00, r);
      chk_val(r, 32'h0000_0002);
      chk_val({31'h0, hresp}, 32'h0000_0000);
      rd(8'h04, r);
      chk_val(r, 32'h0000_0000);
      chk_val({24'h0, ref_en, ref_out}, 32'h0000_0000);
   endtask

   // Reference in 96ths of the supply: low range 4 per step, high range 24 plus 3 per step.
   function automatic logic [6:0] ref_exp(input logic [7:0] v);
      if (!v[7]) return 7'h00;
      return v[5] ? 7'(v[3:0]) * 7'h04 : 7'h18 + 7'(v[3:0]) * 7'h03;
   endfunction

   // Change the comparator while the selected clock is high; only its fall may latch it.
   task latch_case(input logic p);
      logic old;
      pre <= p;
      repeat (20) @(posedge clk_sys);
      @(posedge tsel);
      old = cmp;
      @(posedge clk_sys);
      cmp <= ~old;
      // Raw mode looks before its fall; prescaled mode looks after a raw fall it must ignore.
      repeat (p ? 6 : 2) @(posedge clk_sys);
      chk_val({31'h0, csync}, {31'h0, old});
      @(negedge tsel);
      repeat (4) @(posedge clk_sys);
      chk_val({31'h0, csync}, {31'h0, ~old});
   endtask

   // Counts pulses over 64 cycles; each must fall in a high phase of the selected clock.
   task count_case(input logic [7:0] c, input logic on, en, pn, cm, p, input int exp);
      int n;
      n = 0;
      wr(8'h00, c);
      t_on <= on;
      g_en <= en;
      pin <= pn;
      cmp <= cm;
      pre <= p;
      repeat (20) @(posedge clk_sys);
      chk_val({31'h0, gate}, {31'h0, c[1] ? pn : cm});
      @(posedge tsel);
      repeat (64) begin
         @(posedge clk_sys);
         if (cpulse === 1'b1) begin
            n++;
            chk_val({31'h0, tsel}, 32'h0000_0001);
         end
      end
      chk_val(32'(n), 32'(exp));
   endtask

   // Main sequence.
   initial begin
      logic [7:0] v;
      logic [31:0] r;
      do_reset;
      chk_reset;
      foreach (rows[i]) begin
         wr(rows[i][0], rows[i][1]);
         rd(rows[i][0], r);
         chk_val(r, {24'h0, rows[i][2]});
         if (rows[i][0] == 8'h04) begin
            repeat (3) @(posedge clk_sys);
            chk_val({31'h0, ref_en}, {31'h0, rows[i][2][7]});
            chk_val({25'h0, ref_out}, {25'h0, ref_exp(rows[i][2])});
         end
      end
      for (int k = 0; k < 32; k++) begin
         v = {2'h2, k[4], 1'b0, k[3:0]};
         wr(8'h04, v);
         repeat (3) @(posedge clk_sys);
         chk_val({25'h0, ref_out}, {25'h0, ref_exp(v)});
      end
      wr(8'h00, 8'h01);
      wr(8'h00, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk_val({25'h0, ref_out}, {25'h0, ref_exp(8'hAF)});
      for (int k = 0; k < 2; k++) begin
         cmp <= k[0];
         repeat (2) @(posedge clk_sys);
         chk_val({31'h0, csync}, {31'h0, k[0]});
      end
      wr(8'h00, 8'h01);
      latch_case(1'b1);
      latch_case(1'b0);
      count_case(8'h02, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 0);
      count_case(8'h02, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4);
      count_case(8'h02, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 0);
      count_case(8'h02, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4);
      count_case(8'h00, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4);
      count_case(8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 0);
      count_case(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8);
      wr(8'h04, 8'h8F);
      do_reset;
      chk_reset;
      tally_and_finish;
   end

   // A hang counts as a mismatch and ends the run.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
endmodule // test_comparator_sync_and_vref_control
